// ==== pei_map.vh ====
// Register map, field positions, reset values and filter timing of the protection interrupts
`ifndef PEI_MAP_VH
`define PEI_MAP_VH

// Register offsets
`define PEI_ADDR_FLAG 8'h02
`define PEI_ADDR_BST_TIMING 8'h22
`define PEI_ADDR_PROT 8'h26
`define PEI_ADDR_INT_STATUS 8'h2D
`define PEI_ADDR_INT_MASK 8'h2E
`define PEI_ADDR_DEGLITCH 8'h2F

// Flag register fields
`define PEI_FLAG_RES_BIT 1
`define PEI_FLAG_FREQ_BIT 0

// Boost timing register fields
`define PEI_BST_LATCH_BIT 7

// Protection register fields
`define PEI_PROT_OVERCURRENT_EVENT_BIT 3
`define PEI_PROT_OVERTEMP_EVENT_BIT 2
`define PEI_PROT_OCP_EN_BIT 1
`define PEI_PROT_OTP_EN_BIT 0
`define PEI_PROT_EN_RESET 2'h3

// Interrupt status and mask bit positions
`define PEI_INT_LEAK 11
`define PEI_INT_RES_DMG 10
`define PEI_INT_FREQ_DMG 9
`define PEI_INT_BCK_STB 8
`define PEI_INT_PLL_LCK 7
`define PEI_INT_BST_OC_PRED 6
`define PEI_BATTERY_UNDERVOLTAGE_FLAG 5
`define PEI_SUPPLY_OVERVOLTAGE_FLAG 4
`define PEI_INT_AMP_OC_P 3
`define PEI_INT_AMP_OC_N 2
`define PEI_INT_BST_OC 1
`define PEI_OVERTEMPERATURE_FLAG 0
`define PEI_INT_WIDTH 12
`define PEI_MASK_RESET 12'h07F
`define PEI_DEGLITCH_RESET 12'h500

// Deglitch selects
`define PEI_DG_NONE 2'h0
`define PEI_DG_SHORT 2'h1
`define PEI_DG_MID 2'h2
`define PEI_DG_LONG 2'h3

// Filter times in ns and the clock period in ns
`define PEI_CLK_PERIOD_NS 20
`define PEI_DG_SHORT_NS 40
`define PEI_DG_MID_NS 81
`define PEI_DG_LONG_NS 122

// Least times rounded up to whole clock cycles, sized to the three-bit filter counter
`define PEI_DG_SHORT_CYC 3'h2
`define PEI_DG_MID_CYC 3'h5
`define PEI_DG_LONG_CYC 3'h7

`endif

// ==== pei_deglitch.v ====
// Persistence filter for one fault source with a selectable minimum time
`timescale 1ns/100ps
`include "pei_map.vh"

module pei_deglitch
(
  input wire sys_clk_i,
  input wire reset_i,
  input wire level_i,
  input wire [1:0] select_i,
  output wire level_o
);

  reg [2:0] count_q;
  reg [2:0] count_d;
  reg held_q;
  reg held_d;

  // Cycle count a source must persist for a given select
  function [2:0] pei_need;
    input [1:0] sel;
    begin
      if (sel == `PEI_DG_SHORT)
        pei_need = `PEI_DG_SHORT_CYC;
      else if (sel == `PEI_DG_MID)
        pei_need = `PEI_DG_MID_CYC;
      else
        pei_need = `PEI_DG_LONG_CYC;
    end
  endfunction

  // A low input drops the output at once; only rising needs persistence
  always @*
  begin
    count_d = 3'h0;
    held_d = 1'b0;
    if (level_i)
    begin
      if (count_q + 3'h1 >= pei_need(select_i))
        held_d = 1'b1;
      count_d = held_d ? count_q : count_q + 3'h1;
    end
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      count_q <= 3'h0;
      held_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      held_q <= held_d;
    end
  end

  // No filtering passes the synchronised level straight through
  assign level_o = (select_i == `PEI_DG_NONE) ? level_i : held_q; // see RL7

endmodule

// ==== pei_core.v ====
// Interrupt status, mask, deglitch and protection enables of the speaker amplifier
// Functional notes
// RL1: Twelve interrupt flags sit in status bits 11 to 0, one for each fault or status source.
// RL2: All status flags but bits 10 and 9 stay set until the host reads the status register.
// RL3: Status bit 10 mirrors the resistance damage flag, ignores reads, and clears by writing 0.
// RL4: Status bit 9 mirrors the frequency damage flag, ignores reads, and clears by writing 0.
// RL5: A read/write mask holds one bit per source; bits 6 to 0 reset to 1, bits 11 to 7 to 0.
// RL6: The interrupt output is active while any flag is set whose mask bit is 0.
// RL7: Each two-bit filter select gives no filter, 40ns, 81ns or 122ns of required persistence.
// RL8: The deglitch register holds six selects; the two voltage ones reset to 01, others to 00.
// RL9: Protection enables for over-current and over-temperature reset to 1; bits 3 and 2 show events.
// RL10: With the latch enable bit 7 set, an amplifier over-current shutdown is held, not released.
// RL11: Flag bits 1 and 0 set on coil resistance and resonant frequency damage; the host clears them.
`timescale 1ns/100ps
`include "pei_map.vh"

module pei_core
(
  input wire sys_clk_i,
  input wire reset_i,
  input wire [7:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  input wire air_leak_i,
  input wire bitclock_stable_i,
  input wire pll_locked_i,
  input wire predicted_boost_overcurrent_i,
  input wire battery_undervoltage_i,
  input wire supply_overvoltage_i,
  input wire amp_high_side_overcurrent_i,
  input wire amp_low_side_overcurrent_i,
  input wire boost_overcurrent_i,
  input wire overtemperature_i,
  input wire resistance_damage_i,
  input wire frequency_damage_i,
  output reg irq_o,
  output reg amp_overcurrent_shutdown_o,
  output reg boost_overcurrent_shutdown_o,
  output reg overtemperature_shutdown_o
);

  localparam NSRC = 10;
  localparam NFILT = 6;

  reg [NSRC-1:0] sync1_q;
  reg [NSRC-1:0] sync2_q;
  wire [NSRC-1:0] raw_src;
  wire [NFILT-1:0] filtered;
  wire [`PEI_INT_WIDTH-1:0] events;

  reg resistance_damage_flag_q;
  reg frequency_damage_flag_q;
  reg [`PEI_INT_WIDTH-1:0] status_q;
  reg [`PEI_INT_WIDTH-1:0] status_d;
  reg [`PEI_INT_WIDTH-1:0] mask_q;
  reg [`PEI_INT_WIDTH-1:0] deglitch_q;
  reg overcurrent_protect_en_q;
  reg overtemp_protect_en_q;
  reg overcurrent_event_q;
  reg overtemp_event_q;
  reg amp_overcurrent_latch_enable_q;
  reg amp_oc_latched_q;

  wire wr_flag;
  wire wr_bst;
  wire wr_prot;
  wire wr_mask;
  wire wr_dg;
  wire rd_status;
  wire rd_prot;
  wire amp_oc;
  wire any_oc;
  wire ot_now;

  // Fault comparators are asynchronous to this clock
  assign raw_src = {air_leak_i, bitclock_stable_i, pll_locked_i, predicted_boost_overcurrent_i,
                    battery_undervoltage_i, supply_overvoltage_i, amp_high_side_overcurrent_i,
                    amp_low_side_overcurrent_i, boost_overcurrent_i, overtemperature_i};

  // Two-stage synchroniser, the first stage feeds only the second
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      sync1_q <= {NSRC{1'b0}};
      sync2_q <= {NSRC{1'b0}};
    end
    else
    begin
      sync1_q <= raw_src;
      sync2_q <= sync1_q;
    end
  end

  // One filter for each of the six sources in status bits 5 to 0; select field i belongs to status bit i
  genvar gi;
  generate
    for (gi = 0; gi < NFILT; gi = gi + 1)
    begin : g_filt
      pei_deglitch u_filt
      (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .level_i(sync2_q[gi]),
        .select_i(deglitch_q[2*gi+1:2*gi]),
        .level_o(filtered[gi])
      );
    end
  endgenerate

  // Register access strobes
  assign wr_flag = reg_wr_i && (reg_addr_i == `PEI_ADDR_FLAG);
  assign wr_bst = reg_wr_i && (reg_addr_i == `PEI_ADDR_BST_TIMING);
  assign wr_prot = reg_wr_i && (reg_addr_i == `PEI_ADDR_PROT);
  assign wr_mask = reg_wr_i && (reg_addr_i == `PEI_ADDR_INT_MASK);
  assign wr_dg = reg_wr_i && (reg_addr_i == `PEI_ADDR_DEGLITCH);
  assign rd_status = reg_rd_i && (reg_addr_i == `PEI_ADDR_INT_STATUS);
  assign rd_prot = reg_rd_i && (reg_addr_i == `PEI_ADDR_PROT);

  // Damage flags: set by the detector, cleared by writing 0; the set wins a collision
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      resistance_damage_flag_q <= 1'b0;
      frequency_damage_flag_q <= 1'b0;
    end
    else
    begin
      if (resistance_damage_i)
        resistance_damage_flag_q <= 1'b1; // see RL11
      else if (wr_flag && !reg_wdata_i[`PEI_FLAG_RES_BIT])
        resistance_damage_flag_q <= 1'b0; // see RL3
      if (frequency_damage_i)
        frequency_damage_flag_q <= 1'b1; // see RL11
      else if (wr_flag && !reg_wdata_i[`PEI_FLAG_FREQ_BIT])
        frequency_damage_flag_q <= 1'b0; // see RL4
    end
  end

  // Per-bit event sources in status order
  assign events = {sync2_q[9], 1'b0, 1'b0, sync2_q[8], sync2_q[7], sync2_q[6], filtered}; // see RL1

  // Sticky flags clear on a status read, except the two damage mirrors
  always @*
  begin
    status_d = status_q;
    if (rd_status)
      status_d = {`PEI_INT_WIDTH{1'b0}}; // see RL2
    status_d = status_d | events;
    status_d[`PEI_INT_RES_DMG] = resistance_damage_flag_q; // see RL3
    status_d[`PEI_INT_FREQ_DMG] = frequency_damage_flag_q; // see RL4
  end

  always @(posedge sys_clk_i)
  begin
    if (reset_i)
      status_q <= {`PEI_INT_WIDTH{1'b0}};
    else
      status_q <= status_d; // see RL1
  end

  // Mask, deglitch and latch-enable registers
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      mask_q <= `PEI_MASK_RESET; // see RL5
      deglitch_q <= `PEI_DEGLITCH_RESET; // see RL8
      amp_overcurrent_latch_enable_q <= 1'b0; // see RL10
      {overcurrent_protect_en_q, overtemp_protect_en_q} <= `PEI_PROT_EN_RESET; // see RL9
    end
    else
    begin
      if (wr_mask)
        mask_q <= reg_wdata_i[`PEI_INT_WIDTH-1:0]; // see RL5
      if (wr_dg)
        deglitch_q <= reg_wdata_i[`PEI_INT_WIDTH-1:0]; // see RL8
      if (wr_bst)
        amp_overcurrent_latch_enable_q <= reg_wdata_i[`PEI_BST_LATCH_BIT]; // see RL10
      if (wr_prot)
      begin
        overcurrent_protect_en_q <= reg_wdata_i[`PEI_PROT_OCP_EN_BIT]; // see RL9
        overtemp_protect_en_q <= reg_wdata_i[`PEI_PROT_OTP_EN_BIT]; // see RL9
      end
    end
  end

  assign amp_oc = filtered[`PEI_INT_AMP_OC_P] | filtered[`PEI_INT_AMP_OC_N];
  assign any_oc = amp_oc | filtered[`PEI_INT_BST_OC];
  assign ot_now = filtered[`PEI_OVERTEMPERATURE_FLAG];

  // Event records are sticky and clear on a read of the protection register; set wins
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      overcurrent_event_q <= 1'b0;
      overtemp_event_q <= 1'b0;
    end
    else
    begin
      overcurrent_event_q <= (overcurrent_event_q & ~rd_prot) | any_oc; // see RL9
      overtemp_event_q <= (overtemp_event_q & ~rd_prot) | ot_now; // see RL9
    end
  end

  // The latch holds until the host drops the latch enable or the protection enable,
  // since a latched shutdown with no release path would silence the speaker for good
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
      amp_oc_latched_q <= 1'b0;
    else if (!amp_overcurrent_latch_enable_q || !overcurrent_protect_en_q)
      amp_oc_latched_q <= 1'b0;
    else if (amp_oc)
      amp_oc_latched_q <= 1'b1; // see RL10
  end

  // Shutdown and interrupt outputs, registered to keep them glitch free
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      irq_o <= 1'b0;
      amp_overcurrent_shutdown_o <= 1'b0;
      boost_overcurrent_shutdown_o <= 1'b0;
      overtemperature_shutdown_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(status_q & ~mask_q); // see RL6
      amp_overcurrent_shutdown_o <= overcurrent_protect_en_q & (amp_oc | amp_oc_latched_q); // see RL10
      boost_overcurrent_shutdown_o <= overcurrent_protect_en_q & filtered[`PEI_INT_BST_OC]; // see RL9
      overtemperature_shutdown_o <= overtemp_protect_en_q & ot_now; // see RL9
    end
  end

  // Read data is registered one cycle after the read strobe; unmapped reads give zero
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      if (reg_addr_i == `PEI_ADDR_FLAG)
        reg_rdata_o <= {14'h0000, resistance_damage_flag_q, frequency_damage_flag_q};
      else if (reg_addr_i == `PEI_ADDR_BST_TIMING)
        reg_rdata_o <= {8'h00, amp_overcurrent_latch_enable_q, 7'h00};
      else if (reg_addr_i == `PEI_ADDR_PROT)
        reg_rdata_o <= {12'h000, overcurrent_event_q, overtemp_event_q,
                        overcurrent_protect_en_q, overtemp_protect_en_q};
      else if (reg_addr_i == `PEI_ADDR_INT_STATUS)
        reg_rdata_o <= {4'h0, status_q};
      else if (reg_addr_i == `PEI_ADDR_INT_MASK)
        reg_rdata_o <= {4'h0, mask_q};
      else if (reg_addr_i == `PEI_ADDR_DEGLITCH)
        reg_rdata_o <= {4'h0, deglitch_q};
      else
        reg_rdata_o <= 16'h0000;
    end
  end

endmodule

// ==== pei_core_chk.sv ====
// Checker for register reads, interrupt line and shutdown release
`timescale 1ns/100ps
module pei_core_chk
(
  input wire sys_clk_i,
  input wire reset_i,
  input wire [7:0] reg_addr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire bitclock_stable_i,
  input wire resistance_damage_i,
  input wire overtemperature_i,
  input wire boost_overcurrent_i,
  input wire irq_o,
  input wire boost_overcurrent_shutdown_o,
  input wire overtemperature_shutdown_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Read data may only move after a read strobe
  chk_rdata_holds: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  chk_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 8'h10 |=> !reg_rdata_o)
    else $error("unmapped read");
  chk_status_width: assert property (reg_rd_i && reg_addr_i == 8'h2D |=> !reg_rdata_o[15:12])
    else $error("status top bits");
  chk_mask_width: assert property (reg_rd_i && reg_addr_i == 8'h2E |=> !reg_rdata_o[15:12])
    else $error("mask top bits");
  chk_flag_width: assert property (reg_rd_i && reg_addr_i == 8'h02 |=> !reg_rdata_o[15:2])
    else $error("flag register width");
  chk_latch_only: assert property (reg_rd_i && reg_addr_i == 8'h22 |=> !reg_rdata_o[6:0])
    else $error("timing register bits");
  // Sources whose mask resets to 0 must reach the line within the sync delay
  chk_clock_irq: assert property ($rose(bitclock_stable_i) |-> ##[3:5] irq_o)
    else $error("clock source gave no irq");
  chk_damage_irq: assert property ($rose(resistance_damage_i) |-> ##[1:4] irq_o)
    else $error("damage gave no irq");
  chk_ot_release: assert property ((!overtemperature_i)[*8] |-> ##3 !overtemperature_shutdown_o)
    else $error("ot shutdown stuck");
  chk_oc_release: assert property ((!boost_overcurrent_i)[*8] |-> ##3 !boost_overcurrent_shutdown_o)
    else $error("boost shutdown stuck");
  chk_reset_quiet: assert property ($fell(reset_i) |-> !irq_o)
    else $error("irq after reset");
endmodule

bind pei_core pei_core_chk u_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .bitclock_stable_i(bitclock_stable_i), .resistance_damage_i(resistance_damage_i),
  .overtemperature_i(overtemperature_i), .boost_overcurrent_i(boost_overcurrent_i),
  .irq_o(irq_o), .boost_overcurrent_shutdown_o(boost_overcurrent_shutdown_o),
  .overtemperature_shutdown_o(overtemperature_shutdown_o));

// ==== pei_host.sv ====
// Host model driving the decoded register strobes
`timescale 1ns/100ps
module pei_host
(
  input wire logic sys_clk_i,
  output logic [7:0] reg_addr_o = 8'hA5,
  output logic [15:0] reg_wdata_o = 16'h5A5A,
  output logic reg_wr_o = 1'b0,
  output logic reg_rd_o = 1'b0,
  output logic rd_seen_o
);
  // Marks the cycle in which read data stands
  always @(posedge sys_clk_i)
    rd_seen_o <= reg_rd_o;
  // One access; idle lines inverted so stale values never match
  task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = w;
    reg_rd_o = !w;
    @(posedge sys_clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the protection interrupt core
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] src = 12'h000;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, q[$];
  logic wr, rd, seen, irq, amp_sd, ot_sd, bst_sd;
  logic [31:0] r;
  int bad_count = 0;
  int n_compared = 0;
  int i, k, n;
  logic [7:0] adr[6] = '{8'h2E, 8'h2F, 8'h26, 8'h22, 8'h2D, 8'h02};
  logic [15:0] rv[6] = '{16'h007F, 16'h0500, 16'h0003, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] wm[6] = '{16'h08FF, 16'h0FFF, 16'h0003, 16'h0080, 16'h0000, 16'h0000};
  logic [15:0] ev[6] = '{16'h0007, 16'h000B, 16'h000B, 16'h000B, 16'h0003, 16'h0003};
  int dgn[4] = '{0, 2, 5, 7};
  always #10 clk = ~clk;
  pei_host hst (.sys_clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rd_o(rd), .rd_seen_o(seen));
  // Source vector follows status bit order
  pei_core DUT (.sys_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .air_leak_i(src[11]),
    .resistance_damage_i(src[10]), .frequency_damage_i(src[9]), .bitclock_stable_i(src[8]),
    .pll_locked_i(src[7]), .predicted_boost_overcurrent_i(src[6]),
    .battery_undervoltage_i(src[5]), .supply_overvoltage_i(src[4]),
    .amp_high_side_overcurrent_i(src[3]), .amp_low_side_overcurrent_i(src[2]),
    .boost_overcurrent_i(src[1]), .overtemperature_i(src[0]), .irq_o(irq),
    .amp_overcurrent_shutdown_o(amp_sd), .boost_overcurrent_shutdown_o(bst_sd),
    .overtemperature_shutdown_o(ot_sd));
  task cmp(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_compared++;
    if (got !== ex)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task rdq(input logic [7:0] a, input logic [15:0] ex);
    q.push_back(ex);
    hst.acc(1'b0, a, 16'h0000);
  endtask
  task wrq(input logic [7:0] a, input logic [15:0] d);
    hst.acc(1'b1, a, d);
  endtask
  // Pulse held for len edges, then time for sync, filter and irq to settle
  task pulse(input int b, input int len);
    @(posedge clk);
    #1 src[b] = 1'b1;
    repeat (len) @(posedge clk);
    #1 src[b] = 1'b0;
    repeat (12) @(posedge clk);
    #1;
  endtask
  task conclude;
    if (bad_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Each read result is matched against the oldest noted expectation
  always @(posedge clk)
    if (seen === 1'b1)
      cmp("rdata", q.pop_front(), rdata);
  initial
  begin
    #100000;
    bad_count++;
    conclude;
  end
  initial
  begin
    void'($urandom(32'hBB50A840));
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    for (i = 0; i < 6; i++)
      rdq(adr[i], rv[i]);
    rdq(8'h10, 16'h0000);
    // Random write, read back the stored bits, then restore
    for (i = 0; i < 6; i++)
    begin
      r = $urandom;
      wrq(adr[i], r[15:0] & 16'hF8FF);
      rdq(adr[i], r[15:0] & 16'hF8FF & wm[i]);
      wrq(adr[i], rv[i]);
    end
    pulse(7, 1);
    pulse(8, 1);
    cmp("irq", 16'h0001, {15'h0000, irq});
    rdq(8'h2D, 16'h0180);
    rdq(8'h2D, 16'h0000);
    cmp("irq", 16'h0000, {15'h0000, irq});
    for (i = 0; i < 2; i++)
    begin
      pulse(9 + i, 1);
      rdq(8'h2D, 16'h0200 << i);
      rdq(8'h2D, 16'h0200 << i);
      wrq(8'h02, 16'h0003);
      rdq(8'h02, 16'h0001 << i);
      wrq(8'h02, 16'h0000);
      rdq(8'h2D, 16'h0000);
    end
    // Every select code on a different filtered source
    for (k = 0; k < 6; k++)
    begin
      n = dgn[k % 4];
      wrq(8'h2F, 16'(k % 4) << (2 * k));
      if (n > 1)
      begin
        pulse(k, n - 1);
        rdq(8'h2D, 16'h0000);
      end
      pulse(k, n + 1);
      cmp("irq", 16'h0000, {15'h0000, irq});
      rdq(8'h2D, 16'h0001 << k);
      rdq(8'h26, ev[k]);
    end
    wrq(8'h22, 16'h0080);
    pulse(3, 3);
    cmp("amp_sd", 16'h0001, {15'h0000, amp_sd});
    wrq(8'h22, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    cmp("amp_sd", 16'h0000, {15'h0000, amp_sd});
    // Standing faults shut down until the enables are written 0; events still record
    src[1:0] = 2'h3;
    repeat (6) @(posedge clk);
    #1;
    cmp("ot_sd", 16'h0001, {15'h0000, ot_sd});
    cmp("bst_sd", 16'h0001, {15'h0000, bst_sd});
    wrq(8'h26, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    cmp("ot_sd", 16'h0000, {15'h0000, ot_sd});
    cmp("bst_sd", 16'h0000, {15'h0000, bst_sd});
    rdq(8'h26, 16'h000C);
    wrq(8'h26, 16'h0003);
    src[1:0] = 2'h0;
    conclude;
  end
endmodule
